// file: hw/onchip_memory_decoder.sv
`timescale 1ns/1ps
// Summary of operation
// - CPU 000000h-00FFFFh selects eight dual-access blocks
// - Dual-access block takes two accesses per cycle
// - Dual-access RAM serves program, data, DMA
// - DMA sees dual-access RAM at 0x10000
// - First 192 bytes are mapped control words
// - CPU 010000h-04FFFFh selects 32 single-access blocks
// - Single-access block takes one access per cycle
// - Single-access RAM also serves USB DMA
// - DMA and USB see single-access at 0x90000
// - FE0000h-FFFFFFh selects four-block ROM, reads only
// - Redirect bit routes ROM region to chip-select five
// - Hardware reset clears redirect bit; soft reset not
// - ROM reachable from CPU program and data buses
// - Four CPU reads, two writes per cycle
// - Each DMA one transfer per cycle, independent
// - 16M byte space plus 64K word I/O
// - Unclaimed CPU addresses go to external space
module onchip_memory_decoder
(
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic prog_req_i,
   input wire logic [23:0] prog_addr_i,
   input wire logic [2:0] rd_req_i,
   input wire logic [71:0] rd_addr_i,
   input wire logic [2:0] rd_io_i,
   input wire logic [1:0] wr_req_i,
   input wire logic [47:0] wr_addr_i,
   input wire logic [1:0] wr_io_i,
   input wire logic [3:0] dma_req_i,
   input wire logic [127:0] dma_addr_i,
   input wire logic [3:0] dma_wr_i,
   input wire logic [3:0] dma_io_i,
   input wire logic usb_req_i,
   input wire logic [31:0] usb_addr_i,
   input wire logic usb_wr_i,
   input wire logic status_word_three_wr_i,
   input wire logic rom_redirect_bit_i,
   output logic [10:0] grant_o,
   output logic [10:0] stall_o,
   output logic [10:0] err_o,
   output logic [87:0] target_o,
   output logic [54:0] block_o,
   output logic [263:0] local_o,
   output logic [7:0] dual_access_ram_busy_o,
   output logic [31:0] single_access_ram_busy_o,
   output logic [3:0] rom_busy_o,
   output logic rom_redirect_bit_o
);

   // ------------------------------------------------------------
   // Requestor vectors
   // ------------------------------------------------------------
   localparam int NREQ = memdec_pkg::NREQ;

   logic [NREQ-1:0] req_all;
   logic [NREQ-1:0] wr_all;
   logic [NREQ-1:0] io_all;
   logic [31:0] addr_all [NREQ];
   memdec_pkg::req_class_type cls_all [NREQ];
   memdec_pkg::target_type tgt_w [NREQ];
   logic [4:0] blk_w [NREQ];
   logic [23:0] loc_w [NREQ];
   logic rom_redirect_bit_reg;

   // Program bus is read only; the two write buses always write
   assign req_all = {usb_req_i, dma_req_i, wr_req_i, rd_req_i, prog_req_i};
   assign wr_all = {usb_wr_i, dma_wr_i, 2'h3, 3'h0, 1'b0};
   // I/O space is reached by the data buses and DMA only
   assign io_all = {1'b0, dma_io_i, wr_io_i, rd_io_i, 1'b0};

   assign addr_all[memdec_pkg::REQ_PROG] = {8'h00, prog_addr_i};
   assign cls_all[memdec_pkg::REQ_PROG] = memdec_pkg::CLS_CPU;

   genvar gi;
   generate
      for (gi = 0; gi < memdec_pkg::N_RD; gi++)
      begin : g_rd
         assign addr_all[memdec_pkg::REQ_RD0 + gi] = {8'h00, rd_addr_i[gi*24 +: 24]};
         assign cls_all[memdec_pkg::REQ_RD0 + gi] = memdec_pkg::CLS_CPU;
      end
      for (gi = 0; gi < memdec_pkg::N_WR; gi++)
      begin : g_wr
         assign addr_all[memdec_pkg::REQ_WR0 + gi] = {8'h00, wr_addr_i[gi*24 +: 24]};
         assign cls_all[memdec_pkg::REQ_WR0 + gi] = memdec_pkg::CLS_CPU;
      end
      for (gi = 0; gi < memdec_pkg::N_DMA; gi++)
      begin : g_dma
         assign addr_all[memdec_pkg::REQ_DMA0 + gi] = dma_addr_i[gi*32 +: 32];
         assign cls_all[memdec_pkg::REQ_DMA0 + gi] = memdec_pkg::CLS_DMA;
      end
   endgenerate

   assign addr_all[memdec_pkg::REQ_USB] = usb_addr_i;
   assign cls_all[memdec_pkg::REQ_USB] = memdec_pkg::CLS_USB;

   // ------------------------------------------------------------
   // Per-requestor address decode
   // ------------------------------------------------------------
   generate
      for (gi = 0; gi < NREQ; gi++)
      begin : g_dec
         // CPU view of every memory, DMA view of both RAMs, USB view of single-access RAM
         // ROM or chip-select five for the top region
         region_decode u_dec
         (
            .addr_i(addr_all[gi]),
            .cls_i(cls_all[gi]),
            .wr_i(wr_all[gi]),
            .io_i(io_all[gi]),
            .rom_redirect_i(rom_redirect_bit_reg),
            .target_o(tgt_w[gi]),
            .block_o(blk_w[gi]),
            .local_o(loc_w[gi])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // Block arbitration
   // ------------------------------------------------------------
   logic [NREQ-1:0] grant_next;
   logic [NREQ-1:0] err_next;
   logic [1:0] dual_access_ram_cnt [memdec_pkg::N_DUAL_ACCESS_RAM];
   logic [memdec_pkg::N_SINGLE_ACCESS_RAM-1:0] single_access_ram_taken;
   logic [memdec_pkg::N_ROM-1:0] rom_taken;

   // Lower index wins; losers are stalled and keep their request
   always_comb
   begin
      grant_next = '0;
      err_next = '0;
      single_access_ram_taken = '0;
      rom_taken = '0;
      for (int b = 0; b < memdec_pkg::N_DUAL_ACCESS_RAM; b++)
      begin
         dual_access_ram_cnt[b] = 2'h0;
      end
      for (int r = 0; r < NREQ; r++)
      begin
         if (req_all[r])
         begin
            case (tgt_w[r])
               memdec_pkg::TGT_DUAL_ACCESS_RAM:
               begin
                  // Two accesses of any direction per block
                  if (dual_access_ram_cnt[blk_w[r][2:0]] != memdec_pkg::DUAL_ACCESS_RAM_PORTS)
                  begin
                     grant_next[r] = 1'b1;
                     dual_access_ram_cnt[blk_w[r][2:0]] = dual_access_ram_cnt[blk_w[r][2:0]] + 2'h1;
                  end
               end
               memdec_pkg::TGT_SINGLE_ACCESS_RAM:
               begin
                  // One access per block, USB included
                  if (!single_access_ram_taken[blk_w[r]])
                  begin
                     grant_next[r] = 1'b1;
                     single_access_ram_taken[blk_w[r]] = 1'b1;
                  end
               end
               memdec_pkg::TGT_ROM:
               begin
                  if (!rom_taken[blk_w[r][1:0]])
                  begin
                     grant_next[r] = 1'b1;
                     rom_taken[blk_w[r][1:0]] = 1'b1;
                  end
               end
               memdec_pkg::TGT_NONE:
               begin
                  grant_next[r] = 1'b1;
                  err_next[r] = 1'b1;
               end
               default:
               begin
                  // Mapped words, I/O and external space never stall here
                  grant_next[r] = 1'b1;
               end
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // Output packing
   // ------------------------------------------------------------
   logic [87:0] target_next;
   logic [54:0] block_next;
   logic [263:0] local_next;
   logic [7:0] dual_access_ram_busy_next;

   generate
      for (gi = 0; gi < NREQ; gi++)
      begin : g_pack
         assign target_next[gi*8 +: 8] = req_all[gi] ? tgt_w[gi] : memdec_pkg::TGT_NONE;
         assign block_next[gi*5 +: 5] = blk_w[gi];
         assign local_next[gi*24 +: 24] = loc_w[gi];
      end
      for (gi = 0; gi < memdec_pkg::N_DUAL_ACCESS_RAM; gi++)
      begin : g_busy
         assign dual_access_ram_busy_next[gi] = dual_access_ram_cnt[gi] != 2'h0;
      end
   endgenerate

   // ------------------------------------------------------------
   // Redirect bit
   // ------------------------------------------------------------
   // Of the resets, only hardware reset clears it; no soft reset input exists
   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         rom_redirect_bit_reg <= 1'b0;
      end
      else if (status_word_three_wr_i)
      begin
         rom_redirect_bit_reg <= rom_redirect_bit_i;
      end
   end

   // ------------------------------------------------------------
   // Registered outputs
   // ------------------------------------------------------------
   logic [10:0] grant_reg;
   logic [10:0] stall_reg;
   logic [10:0] err_reg;
   logic [87:0] target_reg;
   logic [54:0] block_reg;
   logic [263:0] local_reg;
   logic [7:0] dual_access_ram_busy_reg;
   logic [31:0] single_access_ram_busy_reg;
   logic [3:0] rom_busy_reg;

   always_ff @(posedge clk_sys_i)
   begin
      if (srst_i)
      begin
         grant_reg <= '0;
         stall_reg <= '0;
         err_reg <= '0;
         target_reg <= {NREQ{memdec_pkg::TGT_NONE}};
         block_reg <= '0;
         local_reg <= '0;
         dual_access_ram_busy_reg <= '0;
         single_access_ram_busy_reg <= '0;
         rom_busy_reg <= '0;
      end
      else
      begin
         grant_reg <= grant_next;
         stall_reg <= req_all & ~grant_next;
         err_reg <= err_next;
         target_reg <= target_next;
         block_reg <= block_next;
         local_reg <= local_next;
         dual_access_ram_busy_reg <= dual_access_ram_busy_next;
         single_access_ram_busy_reg <= single_access_ram_taken;
         rom_busy_reg <= rom_taken;
      end
   end

   assign grant_o = grant_reg;
   assign stall_o = stall_reg;
   assign err_o = err_reg;
   assign target_o = target_reg;
   assign block_o = block_reg;
   assign local_o = local_reg;
   assign dual_access_ram_busy_o = dual_access_ram_busy_reg;
   assign single_access_ram_busy_o = single_access_ram_busy_reg;
   assign rom_busy_o = rom_busy_reg;
   assign rom_redirect_bit_o = rom_redirect_bit_reg;

endmodule : onchip_memory_decoder

// file: include/memdec_pkg.sv
package memdec_pkg;

   // ------------------------------------------------------------
   // Requestor indices
   // ------------------------------------------------------------
   localparam int NREQ = 11;
   localparam int REQ_PROG = 0;
   localparam int REQ_RD0 = 1;
   localparam int REQ_RD1 = 2;
   localparam int REQ_RD2 = 3;
   localparam int REQ_WR0 = 4;
   localparam int REQ_WR1 = 5;
   localparam int REQ_DMA0 = 6;
   localparam int REQ_USB = 10;
   localparam int N_DMA = 4;
   localparam int N_RD = 3;
   localparam int N_WR = 2;

   // ------------------------------------------------------------
   // Widths and capacities
   // ------------------------------------------------------------
   localparam int CPU_AW = 24;
   localparam int BUS_AW = 32;
   localparam int BLK_W = 5;
   localparam int LOC_W = 24;
   localparam int N_DUAL_ACCESS_RAM = 8;
   localparam int N_SINGLE_ACCESS_RAM = 32;
   localparam int N_ROM = 4;
   localparam logic [1:0] DUAL_ACCESS_RAM_PORTS = 2'h2;

   // ------------------------------------------------------------
   // Address map
   // ------------------------------------------------------------
   localparam logic [31:0] CPU_DUAL_ACCESS_RAM_LO = 32'h0000_0000;
   localparam logic [31:0] CPU_DUAL_ACCESS_RAM_HI = 32'h0000_ffff;
   localparam logic [31:0] CPU_SINGLE_ACCESS_RAM_LO = 32'h0001_0000;
   localparam logic [31:0] CPU_SINGLE_ACCESS_RAM_HI = 32'h0004_ffff;
   localparam logic [31:0] CPU_ROM_LO = 32'h00fe_0000;
   localparam logic [31:0] CPU_ROM_HI = 32'h00ff_ffff;
   localparam logic [31:0] CPU_EXT_LO = 32'h0005_0000;
   localparam logic [31:0] DMA_DUAL_ACCESS_RAM_LO = 32'h0001_0000;
   localparam logic [31:0] DMA_DUAL_ACCESS_RAM_HI = 32'h0001_ffff;
   localparam logic [31:0] DMA_SINGLE_ACCESS_RAM_LO = 32'h0009_0000;
   localparam logic [31:0] DMA_SINGLE_ACCESS_RAM_HI = 32'h000c_ffff;
   localparam logic [15:0] MMR_BYTES = 16'h00c0;
   localparam logic [6:0] CPU_SINGLE_ACCESS_RAM_BLK0 = 7'h08;
   localparam logic [6:0] DMA_SINGLE_ACCESS_RAM_BLK0 = 7'h48;

   // ------------------------------------------------------------
   // Requestor classes and decode targets
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      CLS_CPU = 3'h1,
      CLS_DMA = 3'h2,
      CLS_USB = 3'h4
   } req_class_type;

   typedef enum logic [7:0] {
      TGT_NONE = 8'h01,
      TGT_DUAL_ACCESS_RAM = 8'h02,
      TGT_SINGLE_ACCESS_RAM = 8'h04,
      TGT_ROM = 8'h08,
      TGT_MMR = 8'h10,
      TGT_EXT = 8'h20,
      TGT_CS5 = 8'h40,
      TGT_IO = 8'h80
   } target_type;

   function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
                                     input logic [31:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction : in_range

endpackage : memdec_pkg

// file: hw/region_decode.sv
`timescale 1ns/1ps
module region_decode
(
   input wire logic [31:0] addr_i,
   input wire memdec_pkg::req_class_type cls_i,
   input wire logic wr_i,
   input wire logic io_i,
   input wire logic rom_redirect_i,
   output memdec_pkg::target_type target_o,
   output logic [4:0] block_o,
   output logic [23:0] local_o
);

   logic in_cpu_dual_access_ram;
   logic in_cpu_single_access_ram;
   logic in_cpu_rom;
   logic in_dma_dual_access_ram;
   logic in_dma_single_access_ram;
   logic in_mmr;
   logic [6:0] blk_sel;

   assign in_cpu_dual_access_ram = memdec_pkg::in_range(addr_i, memdec_pkg::CPU_DUAL_ACCESS_RAM_LO,
                                              memdec_pkg::CPU_DUAL_ACCESS_RAM_HI);
   assign in_cpu_single_access_ram = memdec_pkg::in_range(addr_i, memdec_pkg::CPU_SINGLE_ACCESS_RAM_LO,
                                              memdec_pkg::CPU_SINGLE_ACCESS_RAM_HI);
   assign in_cpu_rom = memdec_pkg::in_range(addr_i, memdec_pkg::CPU_ROM_LO,
                                            memdec_pkg::CPU_ROM_HI);
   assign in_dma_dual_access_ram = memdec_pkg::in_range(addr_i, memdec_pkg::DMA_DUAL_ACCESS_RAM_LO,
                                              memdec_pkg::DMA_DUAL_ACCESS_RAM_HI);
   assign in_dma_single_access_ram = memdec_pkg::in_range(addr_i, memdec_pkg::DMA_SINGLE_ACCESS_RAM_LO,
                                              memdec_pkg::DMA_SINGLE_ACCESS_RAM_HI);
   assign in_mmr = addr_i[15:0] < memdec_pkg::MMR_BYTES;
   assign blk_sel = addr_i[19:13];

   always_comb
   begin
      target_o = memdec_pkg::TGT_NONE;
      block_o = 5'h00;
      local_o = 24'h00_0000;
      if (io_i && (cls_i != memdec_pkg::CLS_USB))
      begin
         target_o = memdec_pkg::TGT_IO;
         local_o = {8'h00, addr_i[15:0]};
      end
      else if (cls_i == memdec_pkg::CLS_CPU)
      begin
         if (in_cpu_dual_access_ram && in_mmr)
         begin
            target_o = memdec_pkg::TGT_MMR;
            local_o = {8'h00, addr_i[15:0]};
         end
         else if (in_cpu_dual_access_ram)
         begin
            target_o = memdec_pkg::TGT_DUAL_ACCESS_RAM;
            block_o = {2'h0, addr_i[15:13]};
            local_o = {12'h000, addr_i[12:1]};
         end
         else if (in_cpu_single_access_ram)
         begin
            target_o = memdec_pkg::TGT_SINGLE_ACCESS_RAM;
            block_o = 5'(blk_sel - memdec_pkg::CPU_SINGLE_ACCESS_RAM_BLK0);
            local_o = {12'h000, addr_i[12:1]};
         end
         else if (in_cpu_rom && rom_redirect_i)
         begin
            target_o = memdec_pkg::TGT_CS5;
            local_o = addr_i[23:0];
         end
         else if (in_cpu_rom && !wr_i)
         begin
            target_o = memdec_pkg::TGT_ROM;
            block_o = {3'h0, addr_i[16:15]};
            local_o = {10'h000, addr_i[14:1]};
         end
         else if (!in_cpu_rom && (addr_i >= memdec_pkg::CPU_EXT_LO))
         begin
            target_o = memdec_pkg::TGT_EXT;
            local_o = addr_i[23:0];
         end
      end
      else if ((cls_i == memdec_pkg::CLS_DMA) && in_dma_dual_access_ram)
      begin
         target_o = in_mmr ? memdec_pkg::TGT_MMR : memdec_pkg::TGT_DUAL_ACCESS_RAM;
         block_o = {2'h0, addr_i[15:13]};
         local_o = in_mmr ? {8'h00, addr_i[15:0]} : {12'h000, addr_i[12:1]};
      end
      else if (in_dma_single_access_ram)
      begin
         target_o = memdec_pkg::TGT_SINGLE_ACCESS_RAM;
         block_o = 5'(blk_sel - memdec_pkg::DMA_SINGLE_ACCESS_RAM_BLK0);
         local_o = {12'h000, addr_i[12:1]};
      end
   end

endmodule : region_decode

// file: verification/requestor_model.sv
`timescale 1ns/1ps
module requestor_model
(
   input wire logic clk_sys_i,
   input wire logic go_i,
   input wire logic [31:0] cmd_addr_i,
   input wire logic stall_i,
   output logic req_o,
   output logic [31:0] addr_o
);
   logic req_reg = 1'b0;
   logic [31:0] addr_reg = 32'h0;
   assign req_o = req_reg;
   // Idle address shows the inverse so nothing leans on a stale value
   assign addr_o = req_reg ? addr_reg : ~addr_reg;
   always @(posedge clk_sys_i)
   begin
      if (go_i)
      begin
         addr_reg <= cmd_addr_i;
         req_reg <= 1'b1;
      end
      else if (req_reg)
         req_reg <= 1'b0;
      else if (stall_i)
         req_reg <= 1'b1;
   end
endmodule : requestor_model

// file: verification/decoder_monitor.sv
`timescale 1ns/1ps
module decoder_monitor
(
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic prog_req_i,
   input wire logic [23:0] prog_addr_i,
   input wire logic [2:0] rd_req_i,
   input wire logic [1:0] wr_req_i,
   input wire logic [3:0] dma_req_i,
   input wire logic [127:0] dma_addr_i,
   input wire logic [3:0] dma_io_i,
   input wire logic usb_req_i,
   input wire logic [31:0] usb_addr_i,
   input wire logic status_word_three_wr_i,
   input wire logic rom_redirect_bit_i,
   input wire logic [10:0] grant_o,
   input wire logic [10:0] stall_o,
   input wire logic [10:0] err_o,
   input wire logic [87:0] target_o,
   input wire logic [54:0] block_o,
   input wire logic [263:0] local_o,
   input wire logic [7:0] dual_access_ram_busy_o,
   input wire logic [31:0] single_access_ram_busy_o,
   input wire logic [3:0] rom_busy_o,
   input wire logic rom_redirect_bit_o
);
   // ------------
   // Block use by this cycle's grants
   // ------------
   wire logic [10:0] req_vec = {usb_req_i, dma_req_i, wr_req_i, rd_req_i, prog_req_i};
   logic over_cap;
   logic [43:0] busy_exp;
   always_comb
   begin
      int cnt [44];
      int idx;
      idx = -1;
      foreach (cnt[i]) cnt[i] = 0;
      over_cap = 1'b0;
      busy_exp = 44'h000_0000_0000;
      for (int r = 0; r < 11; r++)
      begin
         case (target_o[r*8+:8])
            8'h02: idx = int'(block_o[r*5+:3]);
            8'h04: idx = 8 + int'(block_o[r*5+:5]);
            8'h08: idx = 40 + int'(block_o[r*5+:2]);
            default: idx = -1;
         endcase
         if (grant_o[r] && idx >= 0)
         begin
            cnt[idx]++;
            busy_exp[idx] = 1'b1;
         end
      end
      foreach (cnt[i]) if (cnt[i] > ((i < 8) ? 2 : 1)) over_cap = 1'b1;
   end
   // ------------
   // Properties
   // ------------
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (srst_i);
   sequence s_rom_taken;
      prog_req_i && prog_addr_i >= 24'hfe0000 && !status_word_three_wr_i;
   endsequence
   sequence s_dual_access_ram_taken;
      prog_req_i && prog_addr_i inside {[24'h0000c0:24'h00ffff]};
   endsequence
   sequence s_dma_single_access_ram_taken;
      dma_req_i[0] && !dma_io_i[0] && dma_addr_i[31:0] inside {[32'h00090000:32'h000cffff]};
   endsequence
   sequence s_usb_dual_access_ram_taken;
      usb_req_i && usb_addr_i inside {[32'h00010000:32'h0001ffff]};
   endsequence
   property p_answer;
      (grant_o | stall_o) == $past(req_vec) && (grant_o & stall_o) == 11'h000;
   endproperty
   a_answer: assert property (p_answer)
      else $error("grant and stall do not match last requests");
   property p_capacity;
      !over_cap;
   endproperty
   a_capacity: assert property (p_capacity)
      else $error("block granted beyond its capacity");
   property p_busy;
      {rom_busy_o, single_access_ram_busy_o, dual_access_ram_busy_o} == busy_exp;
   endproperty
   a_busy: assert property (p_busy)
      else $error("busy flags differ from granted blocks");
   property p_redirect_write;
      status_word_three_wr_i |=> rom_redirect_bit_o == $past(rom_redirect_bit_i);
   endproperty
   a_redirect_write: assert property (p_redirect_write)
      else $error("redirect bit not loaded");
   property p_redirect_hold;
      !status_word_three_wr_i |=> $stable(rom_redirect_bit_o);
   endproperty
   a_redirect_hold: assert property (p_redirect_hold)
      else $error("redirect bit changed without a write");
   property p_reset_clear;
      $fell(srst_i) |-> !rom_redirect_bit_o && grant_o == 11'h000;
   endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("reset left redirect bit or grants set");
   property p_rom_region;
      s_rom_taken |=> grant_o[0] && target_o[7:0] == ($past(rom_redirect_bit_o) ? 8'h40 : 8'h08);
   endproperty
   a_rom_region: assert property (p_rom_region)
      else $error("top region routed wrongly");
   property p_prog_dual_access_ram;
      s_dual_access_ram_taken |=> target_o[7:0] == 8'h02 && block_o[4:0] == {2'h0, $past(prog_addr_i[15:13])}
         && local_o[23:0] == {12'h000, $past(prog_addr_i[12:1])};
   endproperty
   a_prog_dual_access_ram: assert property (p_prog_dual_access_ram)
      else $error("program fetch decoded wrongly in dual-access ram");
   property p_dma_single_access_ram;
      s_dma_single_access_ram_taken |=> target_o[55:48] == 8'h04
         && block_o[34:30] == 5'($past(dma_addr_i[19:13]) - 7'h48);
   endproperty
   a_dma_single_access_ram: assert property (p_dma_single_access_ram)
      else $error("dma window to single-access ram decoded wrongly");
   property p_usb_dual_access_ram;
      s_usb_dual_access_ram_taken |=> err_o[10];
   endproperty
   a_usb_dual_access_ram: assert property (p_usb_dual_access_ram)
      else $error("usb reached dual-access ram");
endmodule : decoder_monitor

bind onchip_memory_decoder decoder_monitor u_monitor
(
   .clk_sys_i, .srst_i, .prog_req_i, .prog_addr_i, .rd_req_i, .wr_req_i, .dma_req_i,
   .dma_addr_i, .dma_io_i, .usb_req_i, .usb_addr_i, .status_word_three_wr_i,
   .rom_redirect_bit_i, .grant_o, .stall_o, .err_o, .target_o, .block_o, .local_o,
   .dual_access_ram_busy_o, .single_access_ram_busy_o, .rom_busy_o, .rom_redirect_bit_o
);

// file: verification/tb.sv
`timescale 1ns/1ps
module tb;
   typedef struct packed {logic [3:0] r; logic [7:0] tgt; logic [4:0] blk;
      logic [23:0] loc; logic err;} note_type;
   logic clk_sys_i = 1'b0;
   logic srst_i = 1'b1;
   logic [10:0] go_v = 11'h000;
   logic [31:0] cmd_v [11] = '{default: 32'h0};
   wire logic [10:0] req_v;
   wire logic [31:0] addr_v [11];
   logic [2:0] rd_io = 3'h0;
   logic [1:0] wr_io = 2'h0;
   logic [3:0] dma_wr = 4'h0;
   logic [3:0] dma_io = 4'h0;
   logic usb_wr = 1'h0;
   logic sw3_wr = 1'h0;
   logic redir_in = 1'h0;
   logic [10:0] grant_o, stall_o, err_o;
   logic [87:0] target_o;
   logic [54:0] block_o;
   logic [263:0] local_o;
   logic rom_redirect_bit_o;
   note_type notes [$];
   int fail_count = 0;
   int n_checks = 0;
   always #2.5 clk_sys_i = ~clk_sys_i;
   // ------------
   // Design and requestors
   // ------------
   onchip_memory_decoder dut
   (
      .clk_sys_i(clk_sys_i), .srst_i(srst_i), .prog_req_i(req_v[0]),
      .prog_addr_i(addr_v[0][23:0]), .rd_req_i(req_v[3:1]),
      .rd_addr_i({addr_v[3][23:0], addr_v[2][23:0], addr_v[1][23:0]}), .rd_io_i(rd_io),
      .wr_req_i(req_v[5:4]), .wr_addr_i({addr_v[5][23:0], addr_v[4][23:0]}), .wr_io_i(wr_io),
      .dma_req_i(req_v[9:6]), .dma_addr_i({addr_v[9], addr_v[8], addr_v[7], addr_v[6]}),
      .dma_wr_i(dma_wr), .dma_io_i(dma_io), .usb_req_i(req_v[10]), .usb_addr_i(addr_v[10]),
      .usb_wr_i(usb_wr), .status_word_three_wr_i(sw3_wr), .rom_redirect_bit_i(redir_in),
      .grant_o(grant_o), .stall_o(stall_o), .err_o(err_o), .target_o(target_o),
      .block_o(block_o), .local_o(local_o), .dual_access_ram_busy_o(), .single_access_ram_busy_o(),
      .rom_busy_o(), .rom_redirect_bit_o(rom_redirect_bit_o)
   );
   for (genvar g = 0; g < 11; g++)
   begin : g_req
      requestor_model u_req
      (
         .clk_sys_i(clk_sys_i), .go_i(go_v[g]), .cmd_addr_i(cmd_v[g]),
         .stall_i(stall_o[g]), .req_o(req_v[g]), .addr_o(addr_v[g])
      );
   end
   // ------------
   // Checking
   // ------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
      n_checks++;
      if (seen !== want)
      begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, want, seen);
      end
   endtask : check
   task automatic conclude;
      if (notes.size() != 0)
         fail_count++;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : conclude
   always @(negedge clk_sys_i)
   begin
      note_type n;
      for (int r = 0; r < 11; r++)
      begin
         if (grant_o[r] === 1'b1 && notes.size() == 0)
            check("spare grant", 32'(r), 32'hffffffff);
         else if (grant_o[r] === 1'b1)
         begin
            n = notes.pop_front();
            check("requestor", 32'(r), {28'h0, n.r});
            check("target", {24'h0, target_o[r*8+:8]}, {24'h0, n.tgt});
            check("error", {31'h0, err_o[r]}, {31'h0, n.err});
            if (n.tgt !== 8'h01)
               check("offset", {8'h0, local_o[r*24+:24]}, {8'h0, n.loc});
            if ((n.tgt & 8'h0e) != 8'h00)
               check("block", {27'h0, block_o[r*5+:5]}, {27'h0, n.blk});
         end
      end
   end
   initial
   begin
      #25000;
      fail_count++;
      conclude;
   end
   // ------------
   // Stimulus
   // ------------
   task automatic op(input int r, input logic [31:0] a, input logic [7:0] t,
                     input logic [4:0] b, input logic [23:0] l);
      cmd_v[r] <= a;
      go_v[r] <= 1'b1;
      notes.push_back('{4'(r), t, b, l, t == 8'h01});
   endtask : op
   task automatic fire;
      @(posedge clk_sys_i);
      go_v <= 11'h000;
      for (int i = 0; i < 40 && notes.size() != 0; i++)
         @(posedge clk_sys_i);
      @(posedge clk_sys_i);
   endtask : fire
   initial
   begin
      logic [31:0] a;
      void'($urandom(39));
      repeat (20) @(posedge clk_sys_i);
      srst_i <= 1'b0;
      @(posedge clk_sys_i);
      dma_wr <= 4'h2;
      usb_wr <= 1'h1;
      op(0, 32'h2402, 8'h02, 5'h01, 24'h201);
      op(1, 32'he0fe, 8'h02, 5'h07, 24'h7f);
      op(2, 32'h0010, 8'h10, 5'h00, 24'h10);
      op(3, 32'h00c0, 8'h02, 5'h00, 24'h60);
      op(4, 32'h12000, 8'h04, 5'h01, 24'h0);
      op(5, 32'h4fffe, 8'h04, 5'h1f, 24'hfff);
      op(6, 32'h1c004, 8'h02, 5'h06, 24'h2);
      op(7, 32'hc0002, 8'h04, 5'h18, 24'h1);
      op(8, 32'h20000, 8'h01, 5'h00, 24'h0);
      op(9, 32'h90000, 8'h04, 5'h00, 24'h0);
      op(10, 32'h10200, 8'h01, 5'h00, 24'h0);
      fire;
      rd_io <= 3'h4;
      wr_io <= 2'h2;
      dma_io <= 4'h1;
      op(0, 32'h50000, 8'h20, 5'h00, 24'h50000);
      op(1, 32'hfe0000, 8'h08, 5'h00, 24'h0);
      op(2, 32'hfffffe, 8'h08, 5'h03, 24'h3fff);
      op(3, 32'h0123, 8'h80, 5'h00, 24'h123);
      op(4, 32'hff0000, 8'h01, 5'h00, 24'h0);
      op(5, 32'h1c30, 8'h80, 5'h00, 24'h1c30);
      op(6, 32'h0c04, 8'h80, 5'h00, 24'hc04);
      op(9, 32'h92000, 8'h04, 5'h01, 24'h0);
      fire;
      rd_io <= 3'h0;
      wr_io <= 2'h0;
      dma_io <= 4'h0;
      op(0, 32'h0100, 8'h02, 5'h00, 24'h80);
      op(1, 32'h0102, 8'h02, 5'h00, 24'h81);
      op(4, 32'h0104, 8'h02, 5'h00, 24'h82);
      op(5, 32'h0106, 8'h02, 5'h00, 24'h83);
      fire;
      op(6, 32'h90000, 8'h04, 5'h00, 24'h0);
      op(9, 32'h90002, 8'h04, 5'h00, 24'h1);
      op(10, 32'h90004, 8'h04, 5'h00, 24'h2);
      fire;
      sw3_wr <= 1'h1;
      redir_in <= 1'h1;
      @(posedge clk_sys_i);
      sw3_wr <= 1'h0;
      @(negedge clk_sys_i);
      check("redirect", {31'h0, rom_redirect_bit_o}, 32'h1);
      @(posedge clk_sys_i);
      op(0, 32'hfe0000, 8'h40, 5'h00, 24'hfe0000);
      op(4, 32'hfe0002, 8'h40, 5'h00, 24'hfe0002);
      fire;
      srst_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      srst_i <= 1'b0;
      @(negedge clk_sys_i);
      check("redirect", {31'h0, rom_redirect_bit_o}, 32'h0);
      @(posedge clk_sys_i);
      op(0, 32'hfe0000, 8'h08, 5'h00, 24'h0);
      fire;
      for (int i = 0; i < 16; i++)
      begin
         // Stays below the block kept for the loader
         a = 32'h10000 + (($urandom % 32'h3e000) & 32'h3fffe);
         op(0, a, 8'h04, 5'((a - 32'h10000) >> 13), {12'h0, a[12:1]});
         fire;
      end
      conclude;
   end
endmodule : tb
